// ### rtl/link_regs_pkg.sv
// Constants for the per-port link control and status register block
package link_regs_pkg;
  localparam int            ADDR_W          = 8;
  localparam int            DATA_W          = 32;
  localparam logic [7:0]    OFF_LINK        = 8'hd0;  // Control low half, status high half
  localparam logic [7:0]    OFF_IRQ_STATUS  = 8'he0;  // Sticky event bits, write one to clear
  localparam logic [7:0]    OFF_IRQ_MASK    = 8'he4;  // Interrupt enables, same layout
  localparam logic [7:0]    OFF_OVERRIDE    = 8'he8;  // Slot clock override from management
  // Control field positions
  localparam int            POS_ASPM_LO     = 0;
  localparam int            POS_RCB         = 3;
  localparam int            POS_LINK_DIS    = 4;
  localparam int            POS_RETRAIN     = 5;
  localparam int            POS_COMMON_CLK  = 6;
  localparam int            POS_EXT_SYNC    = 7;
  localparam int            POS_AUTO_WIDTH  = 9;
  localparam int            POS_BW_MGMT_IE  = 10;
  localparam int            POS_AUTO_BW_IE  = 11;
  // Status field positions
  localparam int            POS_SPEED_LO    = 16;
  localparam int            POS_WIDTH_LO    = 20;
  localparam int            POS_TRAIN_ERR   = 26;
  localparam int            POS_TRAINING    = 27;
  localparam int            POS_SLOT_CLK    = 28;
  localparam int            POS_DL_ACTIVE   = 29;
  // Writable control bits: 1:0, 4, 6, 7, 9, 10, 11
  localparam logic [15:0]   CTRL_WR_MASK    = 16'h0ed3;
  localparam logic [15:0]   CTRL_RESET      = 16'h0000;
  localparam logic [3:0]    SPEED_2G5       = 4'h1;
  localparam logic [3:0]    SPEED_5G        = 4'h2;
  localparam logic [5:0]    WIDTH_X1        = 6'h01;
  localparam logic [5:0]    WIDTH_X2        = 6'h02;
  localparam logic [1:0]    ASPM_OFF        = 2'h0;
  localparam logic [1:0]    ASPM_L0S        = 2'h1;
  localparam logic [1:0]    ASPM_L1         = 2'h2;
  localparam logic [1:0]    ASPM_BOTH       = 2'h3;
  localparam int            FTS_EXT         = 4096;
  localparam int            TS1_EXT         = 1024;
  localparam int            CNT_W           = 13;
  // Interrupt event bit positions
  localparam int            EV_TRAIN_ERR    = 0;
  localparam int            EV_TRAIN_DONE   = 1;
  localparam int            EV_DL_UP        = 2;
  localparam int            EV_DL_DOWN      = 3;
  localparam int            EV_BW_MGMT      = 4;
  localparam int            EV_AUTO_BW      = 5;
  localparam int            NUM_EV          = 6;
  // Training tracker states
  typedef enum logic [1:0] {TR_IDLE, TR_ACTIVE, TR_FAILED} train_t;
endpackage : link_regs_pkg

// ### rtl/link_sync2.sv
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
`default_nettype none
module link_sync2 #(
  parameter int W = 1
) (
  input  wire logic         i_clk,   // Core clock
  input  wire logic         i_rst,   // Async reset, active high
  input  wire logic         i_ce,    // Clock enable
  input  wire logic [W-1:0] i_d,     // Asynchronous input
  output logic      [W-1:0] o_q      // Synchronised output
);
  logic [W-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta <= '0;
      o_q  <= '0;
    end else if (i_ce) begin
      meta <= i_d;
      o_q  <= meta;
    end
  end
endmodule : link_sync2
`default_nettype wire

// ### rtl/link_ctrl_status.sv
// Per-port link control and link status register bank
`timescale 1ns/100ps
`default_nettype none
// Function
// - ASPM field gates L0s and L1 entry
// - Receiver may enter L0s regardless of field
// - Read completion boundary bit reads zero
// - Link disable downstream only, resets zero
// - Retrain write starts retraining downstream only
// - Retrain bit always reads zero
// - Common clock bit stored, resets zero
// - Extended sync sets 4096 FTS, 1024 TS1
// - Bandwidth interrupt enables writable downstream only
// - Speed field reports rate, resets 5G
// - Width field resets x2 up, x1 down
// - Training error set on fail, cleared L0
// - Training flag high during training
// - Slot clock from strap, management override
// - DL active bit follows DL_Active state
module link_ctrl_status
  import link_regs_pkg::*;
#(
  parameter bit IS_UPSTREAM = 1'b0
) (
  input  wire logic                              i_clk,           // Port core clock
  input  wire logic                              i_rst,           // Async reset, active high
  input  wire logic                              i_ce,            // Clock enable
  input  wire logic [link_regs_pkg::ADDR_W-1:0]  i_addr,          // Register byte address
  input  wire logic [link_regs_pkg::DATA_W-1:0]  i_wdata,         // Write data
  input  wire logic                              i_wr,            // Write strobe
  input  wire logic                              i_rd,            // Read strobe
  output logic      [link_regs_pkg::DATA_W-1:0]  o_rdata,         // Read data, cycle after strobe
  input  wire logic                              i_train_start,   // Training began (core logic)
  input  wire logic                              i_train_ok,      // Training reached L0
  input  wire logic                              i_train_fail,    // Training failed
  input  wire logic [3:0]                        i_speed,         // Negotiated speed code
  input  wire logic [5:0]                        i_width,         // Negotiated lane count
  input  wire logic                              i_dl_active,     // Data link in DL_Active
  input  wire logic                              i_bw_mgmt_ev,    // Bandwidth management event
  input  wire logic                              i_auto_bw_ev,    // Autonomous bandwidth event
  input  wire logic                              i_slot_clock_strap, // Strap pin, async
  input  wire logic                              i_rx_l0s_req,    // Receiver wants L0s
  output logic                                   o_l0s_tx_en,     // Transmit L0s entry allowed
  output logic                                   o_l1_en,         // L1 entry allowed
  output logic                                   o_rx_l0s_en,     // Receiver L0s entry allowed
  output logic                                   o_link_disable,  // Hold link down
  output logic                                   o_retrain,       // One-cycle retrain pulse
  output logic                                   o_common_clk,    // Shared reference clock
  output logic                                   o_auto_width_dis,// Autonomous width change off
  output logic      [CNT_W-1:0]                  o_fts_count,     // FTS sets on L0s exit, 0 normal
  output logic      [CNT_W-1:0]                  o_ts1_count,     // TS1 sets on L1 exit, 0 normal
  output logic                                   o_irq            // Level interrupt
);
  import link_regs_pkg::*;

  localparam logic [5:0]  WIDTH_RST = IS_UPSTREAM ? WIDTH_X2 : WIDTH_X1;
  localparam logic [15:0] CTRL_MASK_PORT = IS_UPSTREAM ?
    (CTRL_WR_MASK & ~((16'h0001 << POS_LINK_DIS) | (16'h0001 << POS_BW_MGMT_IE)
                      | (16'h0001 << POS_AUTO_BW_IE)))
    : CTRL_WR_MASK;

  // Address decode used by several terms
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction : hit

  logic [15:0]       ctrl;
  logic [3:0]        speed;
  logic [5:0]        width;
  logic              train_err;
  logic              training;
  logic              slot_clk;
  logic              slot_ovr_en;
  logic              slot_ovr_val;
  logic              dl_active;
  logic              dl_active_q;
  logic [NUM_EV-1:0] irq_status;
  logic [NUM_EV-1:0] irq_mask;
  logic              strap_sync;
  train_t            tr_state;
  train_t            next_tr_state;

  // Strap arrives from a pin, so it is synchronised before use
  link_sync2 #(.W(1)) u_strap_sync (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_ce  (i_ce),
    .i_d   (i_slot_clock_strap),
    .o_q   (strap_sync)
  );

  // Write decode
  wire wr_link  = i_wr && hit(i_addr, OFF_LINK);
  wire wr_stat  = i_wr && hit(i_addr, OFF_IRQ_STATUS);
  wire wr_mask  = i_wr && hit(i_addr, OFF_IRQ_MASK);
  wire wr_ovr   = i_wr && hit(i_addr, OFF_OVERRIDE);
  wire [15:0] next_ctrl = (ctrl & ~CTRL_MASK_PORT) | (i_wdata[15:0] & CTRL_MASK_PORT);

  // Retrain never stored, upstream ignores it
  wire retrain_req = wr_link && i_wdata[POS_RETRAIN] && !IS_UPSTREAM;

  // Power state enables from the ASPM field
  wire [1:0] aspm = ctrl[POS_ASPM_LO +: 2];
  assign o_l0s_tx_en = (aspm == ASPM_L0S) || (aspm == ASPM_BOTH);
  assign o_l1_en     = (aspm == ASPM_L1)  || (aspm == ASPM_BOTH);
  // Receiver L0s is not gated by the field, only by its own request
  assign o_rx_l0s_en = i_rx_l0s_req;

  // Status word: reserved, RCB and retrain positions stay zero
  wire [DATA_W-1:0] link_word = {2'h0, dl_active, slot_clk, training, train_err, width, speed,
                                 ctrl};

  // Event sources, set wins over write-one-clear
  wire [NUM_EV-1:0] ev;
  assign ev[EV_TRAIN_ERR]  = i_train_fail;
  assign ev[EV_TRAIN_DONE] = i_train_ok && training;
  assign ev[EV_DL_UP]      = dl_active && !dl_active_q;
  assign ev[EV_DL_DOWN]    = !dl_active && dl_active_q;
  assign ev[EV_BW_MGMT]    = i_bw_mgmt_ev;
  assign ev[EV_AUTO_BW]    = i_auto_bw_ev;
  wire [NUM_EV-1:0] clr = wr_stat ? i_wdata[NUM_EV-1:0] : '0;

  // Training tracker
  always_comb begin
    next_tr_state = tr_state;
    unique case (tr_state)
      TR_IDLE, TR_FAILED: if (i_train_start || retrain_req) next_tr_state = TR_ACTIVE;
      TR_ACTIVE: begin
        if (i_train_fail) next_tr_state = TR_FAILED;
        else if (i_train_ok) next_tr_state = TR_IDLE;
      end
    endcase
  end

  // Read mux
  wire [DATA_W-1:0] rd_mux =
    hit(i_addr, OFF_LINK)       ? link_word :
    hit(i_addr, OFF_IRQ_STATUS) ? {{(DATA_W-NUM_EV){1'b0}}, irq_status} :
    hit(i_addr, OFF_IRQ_MASK)   ? {{(DATA_W-NUM_EV){1'b0}}, irq_mask} :
    hit(i_addr, OFF_OVERRIDE)   ? {30'h0, slot_ovr_en, slot_ovr_val} : '0;

  // Control register and bus answer
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl      <= CTRL_RESET;
      o_rdata   <= '0;
      o_retrain <= 1'b0;
    end else if (i_ce) begin
      if (wr_link) ctrl <= next_ctrl;
      o_rdata   <= i_rd ? rd_mux : '0;
      o_retrain <= retrain_req;
    end
  end

  // Link status tracking
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tr_state    <= TR_IDLE;
      training    <= 1'b0;
      train_err   <= 1'b0;
      speed       <= SPEED_5G;
      width       <= WIDTH_RST;
      dl_active   <= 1'b0;
      dl_active_q <= 1'b0;
    end else if (i_ce) begin
      tr_state    <= next_tr_state;
      training    <= (next_tr_state == TR_ACTIVE);
      if (i_train_fail) train_err <= 1'b1;
      else if (i_train_ok) train_err <= 1'b0;
      if (i_train_ok) begin
        speed <= i_speed;
        width <= i_width;
      end
      dl_active   <= i_dl_active;
      dl_active_q <= dl_active;
    end
  end

  // Slot clock override from management; clearing the enable hands control back to the strap
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      slot_ovr_en  <= 1'b0;
      slot_ovr_val <= 1'b0;
    end else if (i_ce && wr_ovr) begin
      slot_ovr_en  <= i_wdata[1];
      slot_ovr_val <= i_wdata[0];
    end
  end

  // Strap followed continuously: the synchroniser is reset too, so a one-shot capture at
  // release would only ever see zero; the value is valid two cycles after release
  assign slot_clk = slot_ovr_en ? slot_ovr_val : strap_sync;

  // Sticky interrupt status and mask
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_status <= '0;
      irq_mask   <= '0;
    end else if (i_ce) begin
      irq_status <= (irq_status & ~clr) | ev;
      if (wr_mask) irq_mask <= i_wdata[NUM_EV-1:0];
    end
  end

  // Bandwidth event enables in the control word also gate their interrupts; the status bits still set
  wire [NUM_EV-1:0] ev_en = {ctrl[POS_AUTO_BW_IE], ctrl[POS_BW_MGMT_IE], 4'hf};
  assign o_irq = |(irq_status & irq_mask & ev_en);

  // Training set counts from extended sync; zero means the normal count
  assign o_fts_count = ctrl[POS_EXT_SYNC] ? CNT_W'(FTS_EXT) : '0;
  assign o_ts1_count = ctrl[POS_EXT_SYNC] ? CNT_W'(TS1_EXT) : '0;

  assign o_link_disable   = ctrl[POS_LINK_DIS];
  assign o_common_clk     = ctrl[POS_COMMON_CLK];
  assign o_auto_width_dis = ctrl[POS_AUTO_WIDTH];
endmodule : link_ctrl_status
`default_nettype wire

// ### tb/link_ctrl_status_sva.sv
// Checker for the link control and status register bank
`timescale 1ns/100ps
`default_nettype none
module link_ctrl_status_sva
  import link_regs_pkg::*;
(
  input wire logic                              i_clk,          // Clock
  input wire logic                              i_rst,          // Reset
  input wire logic                              i_ce,           // Enable
  input wire logic [link_regs_pkg::ADDR_W-1:0]  i_addr,         // Address
  input wire logic [link_regs_pkg::DATA_W-1:0]  i_wdata,        // Write data
  input wire logic                              i_wr,           // Write
  input wire logic                              i_rd,           // Read
  input wire logic                              i_rx_l0s_req,   // Rx L0s ask
  input wire logic [link_regs_pkg::DATA_W-1:0]  o_rdata,        // Read data
  input wire logic                              o_l0s_tx_en,    // L0s allowed
  input wire logic                              o_l1_en,        // L1 allowed
  input wire logic                              o_rx_l0s_en,    // Rx L0s allowed
  input wire logic                              o_link_disable, // Link held down
  input wire logic                              o_retrain,      // Retrain pulse
  input wire logic [link_regs_pkg::CNT_W-1:0]   o_fts_count     // FTS count
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Decoded bus cycles; outputs are compared one cycle later, when read data stand
  wire rd_link = i_ce && i_rd && i_addr == OFF_LINK;
  wire wr_rt   = i_ce && i_wr && i_addr == OFF_LINK && i_wdata[POS_RETRAIN];
  wire rd_map  = i_addr inside {OFF_LINK, OFF_IRQ_STATUS, OFF_IRQ_MASK, OFF_OVERRIDE};
  a_retrain_pulse: assert property (o_retrain && i_ce && !wr_rt |=> !o_retrain)
    else $error("retrain pulse longer than one cycle");
  a_retrain_cause: assert property (wr_rt |=> o_retrain)
    else $error("retrain write gave no pulse");
  a_retrain_only: assert property (o_retrain |-> $past(wr_rt))
    else $error("retrain pulse without a write");
  a_rd_unmapped: assert property (i_ce && i_rd && !rd_map |=> o_rdata == '0)
    else $error("unmapped read not zero");
  a_rsvd_zero: assert property (rd_link |=> (o_rdata & 32'hc000_f12c) == '0)
    else $error("reserved or retrain bit read nonzero");
  a_aspm_gate: assert property (rd_link |=> o_rdata[1:0] == {o_l1_en, o_l0s_tx_en})
    else $error("power state enables differ from field");
  a_rx_l0s: assert property (o_rx_l0s_en == i_rx_l0s_req)
    else $error("receiver L0s entry gated");
  a_ctrl_out: assert property (rd_link |=> o_rdata[POS_LINK_DIS] == o_link_disable)
    else $error("link disable output differs from bit");
  a_ext_sync: assert property (rd_link |=> o_fts_count == (o_rdata[POS_EXT_SYNC] ?
    CNT_W'(FTS_EXT) : '0)) else $error("FTS count differs from sync bit");
  c_retrain: cover property (o_retrain);
  c_training: cover property (rd_link ##1 o_rdata[POS_TRAINING]);
  c_ext_sync: cover property (rd_link ##1 o_rdata[POS_EXT_SYNC]);
endmodule : link_ctrl_status_sva
bind link_ctrl_status link_ctrl_status_sva i_link_ctrl_status_sva (.i_clk(i_clk),
  .i_rst(i_rst), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .i_rx_l0s_req(i_rx_l0s_req), .o_rdata(o_rdata), .o_l0s_tx_en(o_l0s_tx_en),
  .o_l1_en(o_l1_en), .o_rx_l0s_en(o_rx_l0s_en), .o_link_disable(o_link_disable),
  .o_retrain(o_retrain), .o_fts_count(o_fts_count));
`default_nettype wire

// ### tb/link_partner_model.sv
// Behavioural link partner and training logic answering retrain pulses
`timescale 1ns/100ps
`default_nettype none
module link_partner_model
  import link_regs_pkg::*;
#(
  parameter int DLY = 20
) (
  input  wire logic       i_clk,     // Clock
  input  wire logic       i_rst,     // Reset
  input  wire logic       i_retrain, // Retrain pulse
  input  wire logic       i_fail,    // Make training fail
  output logic            o_ok,      // Reached L0
  output logic            o_fail,    // Training failed
  output logic            o_dl,      // Data link up
  output logic [3:0]      o_speed,   // Speed code
  output logic [5:0]      o_width    // Lane count
);
  int cnt;
  assign o_speed = SPEED_2G5;
  assign o_width = WIDTH_X2;
  // Training lasts DLY cycles; the data link drops meanwhile, as on a real link
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt <= 0;
      o_ok <= 1'b0;
      o_fail <= 1'b0;
      o_dl <= 1'b0;
    end else begin
      cnt <= i_retrain ? DLY : (cnt > 0 ? cnt - 1 : 0);
      o_ok <= cnt == 1 && !i_fail;
      o_fail <= cnt == 1 && i_fail;
      o_dl <= i_retrain ? 1'b0 : (cnt == 1 ? !i_fail : o_dl);
    end
  end
endmodule : link_partner_model
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the link control and status register bank
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import link_regs_pkg::*;
  logic              i_clk = 1'b0, i_rst = 1'b1, i_ce = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
  logic              i_rx_l0s_req = 1'b0, strap = 1'b1, fail = 1'b0, tstart = 1'b0, bwev = 1'b0;
  logic [ADDR_W-1:0] i_addr = '0;
  logic [DATA_W-1:0] i_wdata = '0, o_rdata;
  logic              l0s, l1, rxl0s, ldis, retrain, irq, ok, bad, dl, cclk, awd;
  logic [CNT_W-1:0]  fts, ts1;
  logic [3:0]        spd;
  logic [5:0]        wid;
  int                mismatches = 0, checks_done = 0;
  link_ctrl_status i_link_ctrl_status (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_train_start(tstart), .i_train_ok(ok), .i_train_fail(bad), .i_speed(spd), .i_width(wid),
    .i_dl_active(dl), .i_bw_mgmt_ev(bwev), .i_auto_bw_ev(bwev), .i_slot_clock_strap(strap),
    .i_rx_l0s_req(i_rx_l0s_req), .o_l0s_tx_en(l0s), .o_l1_en(l1), .o_rx_l0s_en(rxl0s),
    .o_link_disable(ldis), .o_retrain(retrain), .o_common_clk(cclk), .o_auto_width_dis(awd),
    .o_fts_count(fts), .o_ts1_count(ts1), .o_irq(irq));
  link_partner_model i_link_partner_model (.i_clk(i_clk), .i_rst(i_rst), .i_retrain(retrain),
    .i_fail(fail), .o_ok(ok), .o_fail(bad), .o_dl(dl), .o_speed(spd), .o_width(wid));
  always #2.5 i_clk = ~i_clk;
  // Comparison with counting
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  // Read, then compare the masked word in the cycle where it stands
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata & m, e);
  endtask : rdc
  // Bounded wait for the interrupt line
  task automatic wait_irq();
    int n = 0;
    while (irq !== 1'b1 && n < 100) begin
      @(posedge i_clk);
      n++;
    end
    if (irq !== 1'b1) begin
      mismatches++;
      summarize();
    end
  endtask : wait_irq
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize
  // Main sequence: reset values, write masking, power states, training paths
  initial begin
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    // Let the strap pass both synchroniser stages before the first read
    repeat (2) @(posedge i_clk);
    rdc(OFF_LINK, '1, 32'h1012_0000);
    rdc(8'hf0, '1, '0);
    $display("test reset values done");
    wr(OFF_LINK, 32'hffff_ffdf);
    rdc(OFF_LINK, 32'h0000_ffff, {16'h0, CTRL_WR_MASK});
    chk(32'({fts, ldis}), 32'({CNT_W'(FTS_EXT), 1'b1}));
    chk(32'({ts1, cclk, awd}), 32'({CNT_W'(TS1_EXT), 2'b11}));
    for (int m = 0; m < 4; m++) begin
      wr(OFF_LINK, 32'(m));
      i_rx_l0s_req <= ~i_rx_l0s_req;
      @(posedge i_clk);
      #1 chk(32'({l1, l0s, rxl0s}), 32'({m[1:0], i_rx_l0s_req}));
    end
    wr(OFF_OVERRIDE, 32'h2);
    rdc(OFF_LINK, 32'h1000_0000, 32'h0);
    wr(OFF_OVERRIDE, 32'h0);
    // A write while the clock enable is low must be lost
    i_ce <= 1'b0;
    wr(OFF_LINK, 32'h40);
    i_ce <= 1'b1;
    rdc(OFF_LINK, 32'h1000_ffff, 32'h1000_0003);
    $display("test control bits done");
    wr(OFF_IRQ_MASK, 32'h3f);
    tstart <= 1'b1;
    @(posedge i_clk);
    tstart <= 1'b0;
    rdc(OFF_LINK, 32'h0800_0000, 32'h0800_0000);
    wr(OFF_LINK, 32'h20);
    rdc(OFF_LINK, 32'h0c00_0020, 32'h0800_0000);
    wait_irq();
    rdc(OFF_LINK, 32'h2fff_0000, 32'h2000_0000 | 32'({WIDTH_X2, SPEED_2G5}) << 16);
    rdc(OFF_IRQ_STATUS, 32'h3f, 32'h06);
    wr(OFF_IRQ_STATUS, 32'h3f);
    #1 chk(32'(irq), 32'h0);
    // Only the training error may raise the line; the link dropping at retrain must not
    wr(OFF_IRQ_MASK, 32'h01);
    fail <= 1'b1;
    wr(OFF_LINK, 32'h20);
    wait_irq();
    rdc(OFF_LINK, 32'h2c00_0000, 32'h0400_0000);
    wr(OFF_IRQ_MASK, 32'h02);
    #1 chk(32'(irq), 32'h0);
    fail <= 1'b0;
    wr(OFF_IRQ_STATUS, 32'h3f);
    wr(OFF_LINK, 32'h20);
    wait_irq();
    rdc(OFF_LINK, 32'h0c00_0000, 32'h0);
    $display("test training done");
    // Bandwidth events stay silent until their control enables are set
    wr(OFF_IRQ_MASK, 32'h30);
    bwev <= 1'b1;
    @(posedge i_clk);
    bwev <= 1'b0;
    #1 chk(32'(irq), 32'h0);
    wr(OFF_LINK, 32'hc00);
    #1 chk(32'(irq), 32'h1);
    $display("test bandwidth events done");
    summarize();
  end
endmodule : tb_top
`default_nettype wire
